// *** common/lcfs_pkg.sv ***
`default_nettype none
package lcfs_pkg;
  // ==========================================================================
  // sizes and counts
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned TMO_W  = 5;
  // time-out in dimming periods, normal dimming
  localparam logic [4:0] TMO_NORMAL_CYC = 5'h06;
  // time-out in pass-through dimming, upper end of the allowed span
  localparam logic [4:0] TMO_PASS_CYC   = 5'h12;
  // reset values
  localparam logic [3:0] CH_EN_RST      = 4'h0;
  localparam logic [4:0] TMO_CNT_RST    = 5'h00;

  // per-channel comparator flags from the analog front end
  typedef struct packed {
    logic [NUM_CH-1:0] short_hi;   // sink voltage above short threshold
    logic [NUM_CH-1:0] at_target;  // current reached target
  } lcfs_ch_flags_t;

  // global flags
  typedef struct packed {
    logic ovlim;    // output_overvoltage_limit reached
    logic overtemp; // die at over-temperature
    logic pwm;      // dimming pwm signal
  } lcfs_glob_flags_t;

  // supervisor state
  typedef enum logic [2:0] {
    LCFS_IDLE = 3'h1,
    LCFS_RUN  = 3'h2,
    LCFS_OFF  = 3'h4
  } lcfs_state_t;
endpackage
`default_nettype wire

// *** rtl/lcfs_chan.sv ***
`timescale 1ns/1ns
`default_nettype none
// one channel fault latch with dimming-period time-out counter
module lcfs_chan (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic       period_i,
  input  wire logic       pass_i,
  input  wire logic       short_hi_i,
  input  wire logic       at_target_i,
  input  wire logic       ovlim_i,
  output var  logic       fault_o
);
  logic       good_q, good_d;
  logic       fault_q, fault_d;
  logic [4:0] cnt_q, cnt_d;
  logic       open_cond;
  logic       bad;
  logic [4:0] limit;

  // ==========================================================================
  // next state
  always_comb
  begin
    good_d    = good_q;
    fault_d   = fault_q;
    cnt_d     = cnt_q;
    limit     = pass_i ? lcfs_pkg::TMO_PASS_CYC : lcfs_pkg::TMO_NORMAL_CYC;
    // open: was good and fell, or never good when limit reached
    open_cond = (good_q && !at_target_i) || (!good_q && ovlim_i);
    bad       = short_hi_i || open_cond;
    if (!run_i)
    begin
      good_d  = 1'b0;
      fault_d = 1'b0;
      cnt_d   = lcfs_pkg::TMO_CNT_RST;  // cleared by re-enable
    end
    else if (!fault_q)
    begin
      if (at_target_i)
        good_d = 1'b1;
      if (!bad)
        cnt_d = lcfs_pkg::TMO_CNT_RST;
      else if (period_i)
      begin
        cnt_d = cnt_q + 5'h01;  // one step per dimming period
        if (cnt_d >= limit)
          fault_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      good_q  <= 1'b0;
      fault_q <= 1'b0;
      cnt_q   <= lcfs_pkg::TMO_CNT_RST;
    end
    else
    begin
      good_q  <= good_d;
      fault_q <= fault_d;
      cnt_q   <= cnt_d;
    end
  end

  assign fault_o = fault_q;
endmodule
`default_nettype wire

// *** rtl/lcfs_top.sv ***
// Notes on behaviour
// - a shorted channel below the short threshold without over-temperature stays driven.
// - over-temperature with a short below threshold turns all channels off until re-enable or reset.
// - a channel above the short threshold faults out after 6 periods, or 18 in pass-through.
// - an open channel times out after 6 periods (18 pass-through) and is switched off.
// - a zener-bypassed open channel below threshold without over-temperature stays on.
// - over-temperature in the zener-bypassed case switches all channels off.
// - another channel pushed above the short threshold switches off after its time-out.
// - over-temperature from mismatch switches all channels off.
// - over the output limit current stays normal and lacking channels fault out on time-out.
// - a channel is good at target, open on a later drop, open at the limit if not good.
// - over-temperature at the die limit stops boosting and turns off the sinks.
`timescale 1ns/1ns
`default_nettype none
module lcfs_top (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     enable_i,
  input  wire logic                     pass_through_dimming_i,
  input  wire lcfs_pkg::lcfs_ch_flags_t   ch_flags_i,
  input  wire lcfs_pkg::lcfs_glob_flags_t glob_flags_i,
  output var  logic [3:0]               ch_en_o,
  output var  logic                     boost_en_o,
  output var  logic                     shutdown_o
);
  // ==========================================================================
  // input synchronisers, two flops per pin
  lcfs_pkg::lcfs_ch_flags_t   ch_s1_q;
  lcfs_pkg::lcfs_ch_flags_t   ch_s2_q;
  lcfs_pkg::lcfs_glob_flags_t gl_s1_q;
  lcfs_pkg::lcfs_glob_flags_t gl_s2_q;
  logic                       en_s1_q;
  logic                       en_s2_q;
  logic                       pt_s1_q;
  logic                       pt_s2_q;

  // channel comparator flags
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ch_s1_q <= '0;
      ch_s2_q <= '0;
    end
    else
    begin
      ch_s1_q <= ch_flags_i;
      ch_s2_q <= ch_s1_q;
    end
  end

  // global comparator flags and dimming pwm
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gl_s1_q <= '0;
      gl_s2_q <= '0;
    end
    else
    begin
      gl_s1_q <= glob_flags_i;
      gl_s2_q <= gl_s1_q;
    end
  end

  // chip enable
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end
    else
    begin
      en_s1_q <= enable_i;
      en_s2_q <= en_s1_q;
    end
  end

  // pass-through dimming mode select
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pt_s1_q <= 1'b0;
      pt_s2_q <= 1'b0;
    end
    else
    begin
      pt_s1_q <= pass_through_dimming_i;
      pt_s2_q <= pt_s1_q;
    end
  end

  // ==========================================================================
  // dimming period detector
  logic pwm_prev_q;
  logic pwm_prev_d;
  logic period;

  // one pulse per dimming period, on the rising pwm edge
  always_comb
  begin
    pwm_prev_d = gl_s2_q.pwm;
    period     = gl_s2_q.pwm && !pwm_prev_q;
  end

  // previous pwm level
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pwm_prev_q <= 1'b0;
    else
      pwm_prev_q <= pwm_prev_d;
  end

  // ==========================================================================
  // supervisor state machine
  lcfs_pkg::lcfs_state_t state_q;
  lcfs_pkg::lcfs_state_t state_d;
  logic                  run;

  // channel latches only count while running
  assign run = (state_q == lcfs_pkg::LCFS_RUN);

  // next state from enable and over-temperature
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      lcfs_pkg::LCFS_IDLE:
      begin
        if (en_s2_q && !gl_s2_q.overtemp)
          state_d = lcfs_pkg::LCFS_RUN;
      end
      lcfs_pkg::LCFS_RUN:
      begin
        if (!en_s2_q)
          state_d = lcfs_pkg::LCFS_IDLE;
        else if (gl_s2_q.overtemp)
          state_d = lcfs_pkg::LCFS_OFF;  // all off
      end
      lcfs_pkg::LCFS_OFF:
      begin
        if (!en_s2_q)
          state_d = lcfs_pkg::LCFS_IDLE;  // left only by re-enable or reset
      end
      default:
      begin
        state_d = lcfs_pkg::LCFS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= lcfs_pkg::LCFS_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================================
  // output enables
  logic [3:0] fault;
  logic [3:0] ch_en_q;
  logic [3:0] ch_en_d;
  logic       boost_q;
  logic       boost_d;
  logic       shut_q;
  logic       shut_d;

  // outputs follow the next state so they change together with it
  always_comb
  begin
    // healthy channels keep running regardless of short/open flags
    ch_en_d = (state_d == lcfs_pkg::LCFS_RUN) ? ~fault : lcfs_pkg::CH_EN_RST;
    // boost keeps running over the limit; stops on over-temperature
    boost_d = (state_d == lcfs_pkg::LCFS_RUN) && (ch_en_d != 4'h0);
    shut_d  = (state_d == lcfs_pkg::LCFS_OFF);
  end

  // output registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ch_en_q <= lcfs_pkg::CH_EN_RST;
      boost_q <= 1'b0;
      shut_q  <= 1'b0;
    end
    else
    begin
      ch_en_q <= ch_en_d;
      boost_q <= boost_d;
      shut_q  <= shut_d;
    end
  end

  // ==========================================================================
  // per-channel fault latches
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      lcfs_chan u_chan (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .run_i      (run),
        .period_i   (period),
        .pass_i     (pt_s2_q),
        .short_hi_i (ch_s2_q.short_hi[g]),
        .at_target_i(ch_s2_q.at_target[g]),
        .ovlim_i    (gl_s2_q.ovlim),
        .fault_o    (fault[g])
      );
    end
  endgenerate

  assign ch_en_o    = ch_en_q;
  assign boost_en_o = boost_q;
  assign shutdown_o = shut_q;
endmodule
`default_nettype wire

// *** dv/lcfs_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// port checker
module lcfs_chk (
  input wire logic                       clk_i,
  input wire logic                       rst_b_i,
  input wire logic                       enable_i,
  input wire lcfs_pkg::lcfs_ch_flags_t   ch_flags_i,
  input wire lcfs_pkg::lcfs_glob_flags_t glob_flags_i,
  input wire logic [3:0]                 ch_en_o,
  input wire logic                       boost_en_o,
  input wire logic                       shutdown_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_off; shutdown_o |-> ch_en_o == 4'h0; endproperty
  a_off: assert property (p_off) else $error("sink on in shutdown");
  property p_bst; shutdown_o |-> !boost_en_o; endproperty
  a_bst: assert property (p_bst) else $error("boost on in shutdown");
  property p_hot; $rose(shutdown_o) |-> $past(glob_flags_i.overtemp, 3); endproperty
  a_hot: assert property (p_hot) else $error("shutdown without heat");
  property p_hold;
    shutdown_o && enable_i && $past(enable_i) && $past(enable_i, 2) |=> shutdown_o;
  endproperty
  a_hold: assert property (p_hold) else $error("shutdown released");
  property p_on; $rose(ch_en_o[0]) |-> $past(enable_i, 3); endproperty
  a_on: assert property (p_on) else $error("sink on while disabled");
  property p_stay; $fell(ch_en_o[0]) && enable_i |=> !ch_en_o[0]; endproperty
  a_stay: assert property (p_stay) else $error("faulted sink back on");
  property p_why;
    $fell(ch_en_o[0]) && !shutdown_o && $past(enable_i, 3) && $past(enable_i, 4)
      && $past(enable_i, 5)
      |-> $past(ch_flags_i.short_hi[0] | ~ch_flags_i.at_target[0], 5);
  endproperty
  a_why: assert property (p_why) else $error("sink off without fault");
  property p_rst; $rose(rst_b_i) |-> ch_en_o == 4'h0 && !shutdown_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
endmodule
bind lcfs_top lcfs_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .enable_i(enable_i),
  .ch_flags_i(ch_flags_i), .glob_flags_i(glob_flags_i), .ch_en_o(ch_en_o),
  .boost_en_o(boost_en_o), .shutdown_o(shutdown_o));
`default_nettype wire

// *** dv/lcfs_fe_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// comparator and sink model
module lcfs_fe_model (
  input  wire logic                       clk_i,
  input  wire logic [3:0]                 en_i,
  input  wire logic [3:0]                 short_i,
  input  wire logic [3:0]                 open_i,
  input  wire logic                       hot_i,
  output var  lcfs_pkg::lcfs_ch_flags_t   ch_o,
  output var  lcfs_pkg::lcfs_glob_flags_t gl_o
);
  logic [3:0] ph_q = 4'h0;
  // free dimming pwm of 10 clocks, flags follow commands
  always @(posedge clk_i)
  begin
    ph_q <= #1 (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
    ch_o <= #1 {short_i, ~open_i};
    gl_o <= #1 {|(open_i & en_i), hot_i, ph_q < 4'h5};
  end
endmodule
`default_nettype wire

// *** dv/lcfs_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcfs_top_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en = 1'b0;
  logic pass = 1'b0;
  logic hot = 1'b0;
  logic [3:0] shrt = 4'h0;
  logic [3:0] opn = 4'h0;
  logic [3:0] ch_en;
  logic boost;
  logic shut;
  lcfs_pkg::lcfs_ch_flags_t chf;
  lcfs_pkg::lcfs_glob_flags_t glf;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  lcfs_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .enable_i(en),
    .pass_through_dimming_i(pass), .ch_flags_i(chf), .glob_flags_i(glf),
    .ch_en_o(ch_en), .boost_en_o(boost), .shutdown_o(shut));
  lcfs_fe_model fe (.clk_i(clk_i), .en_i(ch_en), .short_i(shrt), .open_i(opn),
    .hot_i(hot), .ch_o(chf), .gl_o(glf));
  // ==========
  // clock and watchdog
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic restart(input logic p);
    en = 1'b0;
    pass = p;
    {shrt, opn, hot} = 9'h000;
    wt(6);
    en = 1'b1;
    wt(8);
    chk(ch_en, 4'hF);
  endtask
  // ==========
  // scenarios
  task automatic t_short;
    restart(1'b0);
    shrt = 4'h1;
    wt(45);
    chk(ch_en, 4'hF);
    wt(30);
    chk(ch_en, 4'hE);
    shrt = 4'h0;
    wt(30);
    chk(ch_en, 4'hE);
    $display("short test done");
  endtask
  task automatic t_open;
    restart(1'b1);
    opn = 4'h2;
    wt(170);
    chk({3'h0, boost}, 4'h1);
    chk(ch_en, 4'hF);
    wt(30);
    chk(ch_en, 4'hD);
    $display("open test done");
  endtask
  task automatic t_never;
    en = 1'b0;
    pass = 1'b0;
    shrt = 4'h0;
    opn = 4'h4;
    hot = 1'b0;
    wt(6);
    en = 1'b1;
    wt(20);
    chk(ch_en, 4'hF);
    wt(60);
    chk(ch_en, 4'hB);
    $display("never good test done");
  endtask
  task automatic t_hot;
    restart(1'b0);
    hot = 1'b1;
    wt(5);
    chk(ch_en, 4'h0);
    hot = 1'b0;
    wt(40);
    chk({shut, ch_en[2:0]}, 4'h8);
    $display("heat test done");
  endtask
  task automatic t_reset;
    rst_b_i = 1'b0;
    wt(2);
    chk(ch_en, 4'h0);
    chk({3'h0, shut}, 4'h0);
    rst_b_i = 1'b1;
    wt(8);
    chk(ch_en, 4'hF);
    $display("reset test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    wt(2);
    chk(ch_en, 4'h0);
    rst_b_i = 1'b1;
    t_short();
    t_open();
    t_never();
    t_hot();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
